// ---- rtl/lp_defines.svh ----
`ifndef LP_DEFINES_SVH
`define LP_DEFINES_SVH

// Bus geometry
`define LP_NPORT 4
`define LP_PORT_W 2
`define LP_ADDR_W 5
`define LP_DATA_W 8

// First address that names no port
`define LP_PORT_LIMIT 5'h04

// Reset values
`define LP_BYTE_RST 8'h00
`define LP_FLAGS_RST 4'h0
`define LP_PORT_RST 2'h0

// Cycles a finished port keeps its ready flag low while its level settles
`define LP_HOLD_CYC 3'h7
`define LP_HOLD_ZERO 3'h0

// Width of the status bundle crossed into the bus domain
`define LP_STAT_W 9

`endif

// ---- rtl/lp_pkg.sv ----
`include "lp_defines.svh"

package lp_pkg;

	// Transmit side tracking
	typedef enum logic [0:0] {
		LP_TX_IDLE = 1'b0,
		LP_TX_XFER = 1'b1
	} lp_tx_state_t;

	// One byte written into a port's transmit buffer
	typedef struct packed {
		logic valid;
		logic [`LP_PORT_W-1:0] port;
		logic [`LP_DATA_W-1:0] data;
		logic sop;
		logic eop;
		logic err;
	} lp_tx_word_t;

	// Head of the selected port's receive buffer
	typedef struct packed {
		logic avail;
		logic [`LP_DATA_W-1:0] data;
		logic eop;
		logic err;
		logic last;
	} lp_rx_head_t;

	// Receive outputs toward the link layer
	typedef struct packed {
		logic valid;
		logic [`LP_DATA_W-1:0] data;
		logic sop;
		logic eop;
		logic err;
	} lp_rx_out_t;

endpackage : lp_pkg

// ---- rtl/lp_sync_bits.sv ----
`timescale 1ns/1ps

module lp_sync_bits #(
	parameter int W = 1
) (
	// Destination clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Level from the other domain
	input wire logic [W-1:0] i_d,
	// Level in this domain
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// Two stages; the first is read by the second only
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_d;
			sync_ff <= meta_ff;
		end
	end

	assign o_q = sync_ff;

endmodule : lp_sync_bits

// ---- rtl/lp_phy_port.sv ----
// How it works
// - Direct mode: each port drops its transmit room flag when full.
// - Direct mode: port raises its room flag again when a block fits.
// - Direct mode: port raises ready flag while holding a block or end.
// - After address change old port stops; new one starts next edge.
// - Receive start mark only with the first byte of a packet.
// - Enable dropped: next edge valid low and receive outputs released.
// - Resumed packet shows valid and next byte without a start mark.
// - End mark comes with the last byte; next edge valid and end drop.
// - Direct mode: ready flag drops with the packet end if nothing remains.
// - Polled mode: shared room flag answers a poll one edge later.
// - Polled mode: selected room flag driven two cycles after start, released on handover.
// - Polled mode: shared ready flag answers a poll one edge later.
// - Polled receive: address plus enable, port starts next edge.
// - Polled mode: outputs released the edge after enable drops.
// - Same sequencing whether the same or another port is picked next.
`timescale 1ns/1ps
`include "lp_defines.svh"

module lp_phy_port (
	// System clock side
	input wire logic I_CLK_SYS,
	input wire logic I_RST_B,
	input wire logic I_POLLED_MODE,
	input wire logic [`LP_NPORT-1:0] I_TX_ROOM,
	input wire logic [`LP_NPORT-1:0] I_RX_BLOCK,
	// Bus clock from the link layer
	input wire logic I_BUS_CLK,
	// Transmit bus inputs
	input wire logic I_TX_TRANSFER_ENABLE_N,
	input wire logic [`LP_ADDR_W-1:0] I_TX_PORT_ADDRESS,
	input wire logic [`LP_DATA_W-1:0] I_TX_DATA,
	input wire logic I_TX_FIRST_BYTE_MARK,
	input wire logic I_TX_LAST_BYTE_MARK,
	input wire logic I_TX_ERROR_MARK,
	// Transmit bus outputs
	output logic [`LP_NPORT-1:0] O_TX_PORT_ROOM_FLAG,
	output logic O_TX_POLLED_ROOM_FLAG,
	output logic O_TX_SELECTED_ROOM_FLAG,
	output logic O_TX_SELECTED_ROOM_FLAG_OE,
	// Transmit buffer write side
	output lp_pkg::lp_tx_word_t O_TX_WR,
	output logic O_TX_SEQ_FAULT,
	// Receive bus inputs
	input wire logic I_RX_TRANSFER_ENABLE_N,
	input wire logic [`LP_ADDR_W-1:0] I_RX_PORT_ADDRESS,
	// Receive bus outputs
	output lp_pkg::lp_rx_out_t O_RX_OUT,
	output logic O_RX_OUT_OE,
	output logic [`LP_NPORT-1:0] O_RX_PORT_READY_FLAG,
	output logic O_RX_POLLED_READY_FLAG,
	// Receive buffer read side
	input wire lp_pkg::lp_rx_head_t I_RX_HEAD,
	output logic [`LP_PORT_W-1:0] O_RX_RD_PORT,
	output logic O_RX_RD_POP
);

	// Address decode shared by both directions
	function automatic logic addr_ok(input logic [`LP_ADDR_W-1:0] a);
		addr_ok = (a < `LP_PORT_LIMIT);
	endfunction : addr_ok

	function automatic logic [`LP_PORT_W-1:0] port_of(
		input logic [`LP_ADDR_W-1:0] a);
		port_of = a[`LP_PORT_W-1:0];
	endfunction : port_of

	// System clock domain
	logic mode_ff;
	logic mode_taken_ff;
	logic [`LP_NPORT-1:0] room_src_ff;
	logic [`LP_NPORT-1:0] ready_src_ff;
	logic [`LP_STAT_W-1:0] stat_src;

	// Strap is caught once after reset release, so a late flip is ignored
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			mode_ff <= 1'b0;
			mode_taken_ff <= 1'b0;
		end else if (!mode_taken_ff) begin
			mode_ff <= I_POLLED_MODE;
			mode_taken_ff <= 1'b1;
		end
	end

	// Launch flops so the crossing sees glitch-free levels
	always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
		if (!I_RST_B) begin
			room_src_ff <= `LP_FLAGS_RST;
			ready_src_ff <= `LP_FLAGS_RST;
		end else begin
			room_src_ff <= I_TX_ROOM;
			ready_src_ff <= I_RX_BLOCK;
		end
	end

	assign stat_src = {mode_ff, ready_src_ff, room_src_ff};

	// Bus clock domain
	logic rst_meta_ff;
	logic rst_sync_ff;
	wire bus_rst_b = rst_sync_ff;

	// Reset asserts at once and releases on the bus clock
	always_ff @(posedge I_BUS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	logic [`LP_STAT_W-1:0] stat_bus;

	// Status levels cross as plain levels; each bit is independent
	lp_sync_bits #(
		.W(`LP_STAT_W)
	) u_stat_sync (
		.i_clk(I_BUS_CLK),
		.i_rst_b(bus_rst_b),
		.i_d(stat_src),
		.o_q(stat_bus)
	);

	wire [`LP_NPORT-1:0] room_sync = stat_bus[`LP_NPORT-1:0];
	wire [`LP_NPORT-1:0] ready_sync = stat_bus[2*`LP_NPORT-1:`LP_NPORT];
	wire polled = stat_bus[2*`LP_NPORT];

	// Transmit
	lp_pkg::lp_tx_state_t tx_state_ff;
	lp_pkg::lp_tx_state_t nxt_tx_state;
	logic [`LP_PORT_W-1:0] tx_sel_ff;
	logic [`LP_PORT_W-1:0] nxt_tx_sel;
	logic tx_start_d_ff;
	logic spa_ff;
	logic spa_oe_ff;
	logic nxt_spa_oe;
	logic [`LP_NPORT-1:0] tx_room_ff;
	logic tx_poll_ff;
	logic [`LP_NPORT-1:0] tx_mid_ff;
	logic [`LP_NPORT-1:0] nxt_tx_mid;
	logic seq_fault_ff;
	lp_pkg::lp_tx_word_t tx_wr_ff;
	lp_pkg::lp_tx_word_t nxt_tx_wr;

	wire tx_en = !I_TX_TRANSFER_ENABLE_N;
	wire tx_hit = tx_en && addr_ok(I_TX_PORT_ADDRESS);
	wire [`LP_PORT_W-1:0] tx_port = port_of(I_TX_PORT_ADDRESS);
	wire tx_mid_here = tx_mid_ff[tx_port];

	// A transfer starts on a fresh enable or on a start mark under enable
	wire tx_start = tx_hit &&
		(tx_state_ff == lp_pkg::LP_TX_IDLE || I_TX_FIRST_BYTE_MARK);
	wire tx_handover = tx_start && (tx_port != tx_sel_ff);
	wire [`LP_PORT_W-1:0] poll_tx_port = port_of(I_TX_PORT_ADDRESS);
	wire tx_poll_nxt = addr_ok(I_TX_PORT_ADDRESS) &&
		room_sync[poll_tx_port];

	// Transfer tracking: enable held means a transfer is running
	always_comb begin
		nxt_tx_state = tx_en ? lp_pkg::LP_TX_XFER : lp_pkg::LP_TX_IDLE;
		nxt_tx_sel = tx_start ? tx_port : tx_sel_ff;
	end

	// Selected-port flag drives two cycles after start, released on handover
	always_comb begin
		nxt_spa_oe = spa_oe_ff;
		if (!polled) begin
			nxt_spa_oe = 1'b0;
		end else if (tx_start_d_ff) begin
			nxt_spa_oe = 1'b1;
		end else if (tx_handover) begin
			nxt_spa_oe = 1'b0;
		end
	end

	// Byte into the addressed port's buffer; error kept only on the end byte
	always_comb begin
		nxt_tx_wr.valid = tx_hit;
		nxt_tx_wr.port = tx_port;
		nxt_tx_wr.data = I_TX_DATA;
		nxt_tx_wr.sop = I_TX_FIRST_BYTE_MARK;
		nxt_tx_wr.eop = I_TX_LAST_BYTE_MARK;
		nxt_tx_wr.err = I_TX_ERROR_MARK && I_TX_LAST_BYTE_MARK;
	end

	// Packet state per port, so a resumed packet needs no start mark
	always_comb begin
		nxt_tx_mid = tx_mid_ff;
		for (int p = 0; p < `LP_NPORT; p++) begin
			if (tx_hit && tx_port == `LP_PORT_W'(p)) begin
				nxt_tx_mid[p] = !I_TX_LAST_BYTE_MARK;
			end
		end
	end

	// Byte with no start mark to a port between packets is flagged
	wire tx_fault = tx_hit && !tx_mid_here && !I_TX_FIRST_BYTE_MARK;

	always_ff @(posedge I_BUS_CLK or negedge bus_rst_b) begin
		if (!bus_rst_b) begin
			tx_state_ff <= lp_pkg::LP_TX_IDLE;
			tx_sel_ff <= `LP_PORT_RST;
			tx_start_d_ff <= 1'b0;
			spa_oe_ff <= 1'b0;
			tx_mid_ff <= `LP_FLAGS_RST;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_sel_ff <= nxt_tx_sel;
			tx_start_d_ff <= tx_start;
			spa_oe_ff <= nxt_spa_oe;
			tx_mid_ff <= nxt_tx_mid;
		end
	end

	// Room flags: per port in direct mode, answer to a poll in polled mode
	always_ff @(posedge I_BUS_CLK or negedge bus_rst_b) begin
		if (!bus_rst_b) begin
			tx_room_ff <= `LP_FLAGS_RST;
			tx_poll_ff <= 1'b0;
			spa_ff <= 1'b0;
		end else begin
			tx_room_ff <= polled ? `LP_FLAGS_RST : room_sync;
			tx_poll_ff <= polled && tx_poll_nxt;
			spa_ff <= room_sync[nxt_tx_sel];
		end
	end

	// Write word and fault pulse are registered toward the buffer
	always_ff @(posedge I_BUS_CLK or negedge bus_rst_b) begin
		if (!bus_rst_b) begin
			tx_wr_ff <= '0;
			seq_fault_ff <= 1'b0;
		end else begin
			tx_wr_ff <= nxt_tx_wr;
			seq_fault_ff <= tx_fault;
		end
	end

	assign O_TX_PORT_ROOM_FLAG = tx_room_ff;
	assign O_TX_POLLED_ROOM_FLAG = tx_poll_ff;
	assign O_TX_SELECTED_ROOM_FLAG = spa_ff && spa_oe_ff;
	assign O_TX_SELECTED_ROOM_FLAG_OE = spa_oe_ff;
	assign O_TX_WR = tx_wr_ff;
	assign O_TX_SEQ_FAULT = seq_fault_ff;

	// Receive
	lp_pkg::lp_rx_out_t rx_out_ff;
	lp_pkg::lp_rx_out_t nxt_rx_out;
	logic rx_oe_ff;
	logic rx_gap_ff;
	logic [`LP_NPORT-1:0] rx_mid_ff;
	logic [`LP_NPORT-1:0] nxt_rx_mid;
	logic [`LP_NPORT-1:0] hold_ff;
	logic [`LP_NPORT-1:0] nxt_hold;
	logic [2:0] hold_cnt_ff [`LP_NPORT];
	logic [2:0] nxt_hold_cnt [`LP_NPORT];
	logic [`LP_NPORT-1:0] rdy_flag_ff;
	logic [`LP_NPORT-1:0] nxt_rdy_flag;
	logic rx_poll_ff;

	wire rx_en = !I_RX_TRANSFER_ENABLE_N;
	wire [`LP_PORT_W-1:0] rx_port = port_of(I_RX_PORT_ADDRESS);
	wire rx_addr_ok = addr_ok(I_RX_PORT_ADDRESS);

	// A byte leaves when enabled, addressed and the port has one,
	// except the cycle right after an end byte, which stays empty
	wire rx_send = rx_en && rx_addr_ok && I_RX_HEAD.avail && !rx_gap_ff;
	wire rx_end = rx_send && I_RX_HEAD.eop;
	wire rx_drained = rx_end && I_RX_HEAD.last;

	// Output word; start mark only on a packet's first byte
	always_comb begin
		nxt_rx_out.valid = rx_send;
		nxt_rx_out.data = rx_send ? I_RX_HEAD.data : `LP_BYTE_RST;
		nxt_rx_out.sop = rx_send && !rx_mid_ff[rx_port];
		nxt_rx_out.eop = rx_end;
		nxt_rx_out.err = rx_end && I_RX_HEAD.err;
	end

	// Per port packet state survives handovers, so resumes skip the mark
	always_comb begin
		nxt_rx_mid = rx_mid_ff;
		for (int p = 0; p < `LP_NPORT; p++) begin
			if (rx_send && rx_port == `LP_PORT_W'(p)) begin
				nxt_rx_mid[p] = !I_RX_HEAD.eop;
			end
		end
	end

	// The ready level lags by the crossing, so a drained port masks its
	// own flag until the level falls or a short hold expires
	always_comb begin
		for (int p = 0; p < `LP_NPORT; p++) begin
			nxt_hold[p] = hold_ff[p];
			nxt_hold_cnt[p] = hold_cnt_ff[p];
			if (rx_drained && rx_port == `LP_PORT_W'(p)) begin
				nxt_hold[p] = 1'b1;
				nxt_hold_cnt[p] = `LP_HOLD_CYC;
			end else if (!ready_sync[p] ||
				hold_cnt_ff[p] == `LP_HOLD_ZERO) begin
				nxt_hold[p] = 1'b0;
				nxt_hold_cnt[p] = `LP_HOLD_ZERO;
			end else begin
				nxt_hold_cnt[p] = hold_cnt_ff[p] - 3'h1;
			end
			nxt_rdy_flag[p] = !polled && ready_sync[p] &&
				!nxt_hold[p];
		end
	end

	wire rx_poll_nxt = polled && rx_addr_ok && ready_sync[rx_port] &&
		!hold_ff[rx_port];

	// Bus outputs follow enable by one edge; released while it is off
	always_ff @(posedge I_BUS_CLK or negedge bus_rst_b) begin
		if (!bus_rst_b) begin
			rx_out_ff <= '0;
			rx_oe_ff <= 1'b0;
			rx_gap_ff <= 1'b0;
		end else begin
			rx_out_ff <= nxt_rx_out;
			rx_oe_ff <= rx_en;
			rx_gap_ff <= rx_end;
		end
	end

	// Per port bookkeeping
	always_ff @(posedge I_BUS_CLK or negedge bus_rst_b) begin
		if (!bus_rst_b) begin
			rx_mid_ff <= `LP_FLAGS_RST;
			hold_ff <= `LP_FLAGS_RST;
			hold_cnt_ff <= '{default: `LP_HOLD_ZERO};
		end else begin
			rx_mid_ff <= nxt_rx_mid;
			hold_ff <= nxt_hold;
			hold_cnt_ff <= nxt_hold_cnt;
		end
	end

	// Ready flags: direct per port, or poll answer one edge later
	always_ff @(posedge I_BUS_CLK or negedge bus_rst_b) begin
		if (!bus_rst_b) begin
			rdy_flag_ff <= `LP_FLAGS_RST;
			rx_poll_ff <= 1'b0;
		end else begin
			rdy_flag_ff <= nxt_rdy_flag;
			rx_poll_ff <= rx_poll_nxt;
		end
	end

	// Pop is combinational so the head advances with the byte taken
	assign O_RX_RD_PORT = rx_port;
	assign O_RX_RD_POP = rx_send;
	assign O_RX_OUT = rx_oe_ff ? rx_out_ff : '0;
	assign O_RX_OUT_OE = rx_oe_ff;
	assign O_RX_PORT_READY_FLAG = rdy_flag_ff;
	assign O_RX_POLLED_READY_FLAG = rx_poll_ff;

endmodule : lp_phy_port

// ---- dv/lp_phy_port_asserts.sv ----
`timescale 1ns/1ps
`include "lp_defines.svh"

module lp_phy_port_asserts (
	// Clock, reset and strap
	input wire logic I_BUS_CLK,
	input wire logic I_RST_B,
	input wire logic I_POLLED_MODE,
	// Transmit bus
	input wire logic I_TX_TRANSFER_ENABLE_N,
	input wire logic [`LP_ADDR_W-1:0] I_TX_PORT_ADDRESS,
	input wire logic [`LP_DATA_W-1:0] I_TX_DATA,
	input wire logic I_TX_FIRST_BYTE_MARK,
	input wire lp_pkg::lp_tx_word_t O_TX_WR,
	input wire logic O_TX_SELECTED_ROOM_FLAG_OE,
	input wire logic [`LP_NPORT-1:0] O_TX_PORT_ROOM_FLAG,
	input wire logic O_TX_POLLED_ROOM_FLAG,
	// Receive bus
	input wire logic I_RX_TRANSFER_ENABLE_N,
	input wire logic [`LP_ADDR_W-1:0] I_RX_PORT_ADDRESS,
	input wire lp_pkg::lp_rx_head_t I_RX_HEAD,
	input wire lp_pkg::lp_rx_out_t O_RX_OUT,
	input wire logic O_RX_OUT_OE,
	input wire logic O_RX_RD_POP
);
	default clocking cb @(posedge I_BUS_CLK);
	endclocking
	default disable iff (!I_RST_B);

	// Start byte to a real port, then a byte to the same port
	sequence tx_start;
		!I_TX_TRANSFER_ENABLE_N && I_TX_FIRST_BYTE_MARK &&
			I_TX_PORT_ADDRESS < `LP_PORT_LIMIT;
	endsequence
	sequence tx_hold;
		!I_TX_TRANSFER_ENABLE_N && $stable(I_TX_PORT_ADDRESS);
	endsequence

	chk_tx_wr_follow: assert property (tx_start |=>
		O_TX_WR.valid && O_TX_WR.sop && O_TX_WR.data == $past(I_TX_DATA) &&
		{3'h0, O_TX_WR.port} == $past(I_TX_PORT_ADDRESS))
		else $error("start byte not written to its port");
	chk_err_with_eop: assert property (O_TX_WR.err |-> O_TX_WR.eop)
		else $error("error mark without end mark");
	chk_sel_drive: assert property (
		(tx_start ##0 I_POLLED_MODE) ##1 tx_hold |=> O_TX_SELECTED_ROOM_FLAG_OE)
		else $error("selected room flag not driven");
	chk_mode_flags: assert property (I_POLLED_MODE ?
		O_TX_PORT_ROOM_FLAG == 4'h0 : !O_TX_POLLED_ROOM_FLAG)
		else $error("room flag of the other mode driven");
	chk_rx_pop_byte: assert property (O_RX_RD_POP |=>
		O_RX_OUT.valid && O_RX_OUT_OE && O_RX_OUT.data == $past(I_RX_HEAD.data))
		else $error("popped byte not presented");
	chk_rx_pop_cause: assert property (!I_RX_TRANSFER_ENABLE_N &&
		I_RX_PORT_ADDRESS < `LP_PORT_LIMIT && I_RX_HEAD.avail &&
		!O_RX_OUT.eop |-> O_RX_RD_POP)
		else $error("available byte not taken");
	chk_rx_sop_once: assert property (
		O_RX_OUT.sop && $stable(I_RX_PORT_ADDRESS) |=> !O_RX_OUT.sop)
		else $error("start mark on two bytes");
	chk_rx_en_off: assert property (I_RX_TRANSFER_ENABLE_N |=>
		!O_RX_OUT_OE && !O_RX_OUT.valid)
		else $error("receive outputs still driven");
	chk_rx_eop_end: assert property (O_RX_OUT.eop |=>
		!O_RX_OUT.valid && !O_RX_OUT.eop)
		else $error("valid or end mark held after end");
endmodule : lp_phy_port_asserts

bind lp_phy_port lp_phy_port_asserts u_chk (.I_BUS_CLK, .I_RST_B,
	.I_POLLED_MODE, .I_TX_TRANSFER_ENABLE_N, .I_TX_PORT_ADDRESS, .I_TX_DATA,
	.I_TX_FIRST_BYTE_MARK, .O_TX_WR, .O_TX_SELECTED_ROOM_FLAG_OE,
	.O_TX_PORT_ROOM_FLAG, .O_TX_POLLED_ROOM_FLAG, .I_RX_TRANSFER_ENABLE_N,
	.I_RX_PORT_ADDRESS, .I_RX_HEAD, .O_RX_OUT, .O_RX_OUT_OE, .O_RX_RD_POP);

// ---- dv/lp_link_model.sv ----
`timescale 1ns/1ps
`include "lp_defines.svh"

module lp_link_model (
	// Bus clock
	input wire logic i_clk,
	// Transmit bus toward the port
	output logic o_tx_en_n,
	output logic [`LP_ADDR_W-1:0] o_tx_addr,
	output logic [`LP_DATA_W-1:0] o_tx_data,
	output logic o_tx_sop,
	output logic o_tx_eop,
	output logic o_tx_err,
	// Receive bus toward the port
	output logic o_rx_en_n,
	output logic [`LP_ADDR_W-1:0] o_rx_addr
);
	// Both buses idle from time zero
	initial begin
		o_tx_en_n = 1'b1;
		o_tx_addr = 5'h00;
		o_tx_data = 8'h5a;
		{o_tx_sop, o_tx_eop, o_tx_err} = 3'h0;
		o_rx_en_n = 1'b1;
		o_rx_addr = 5'h00;
	end

	// One byte, launched off the edge and held a whole cycle
	task automatic tx(input logic [4:0] a, input logic [7:0] d,
		input logic s, e, r);
		@(negedge i_clk);
		o_tx_en_n <= 1'b0;
		o_tx_addr <= a;
		o_tx_data <= d;
		{o_tx_sop, o_tx_eop, o_tx_err} <= {s, e, r};
	endtask : tx

	// Enable off; data inverts so a released bus never repeats a byte
	task automatic tx_idle(input logic [4:0] a);
		@(negedge i_clk);
		o_tx_en_n <= 1'b1;
		o_tx_addr <= a;
		o_tx_data <= ~o_tx_data;
		{o_tx_sop, o_tx_eop, o_tx_err} <= 3'h0;
	endtask : tx_idle

	// Address and enable change together, held a cycle
	task automatic rx(input logic [4:0] a, input logic en_n);
		@(negedge i_clk);
		o_rx_en_n <= en_n;
		o_rx_addr <= a;
	endtask : rx
endmodule : lp_link_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
	logic clk = 0, bclk = 0, rst_b = 0, mode = 0;
	logic [3:0] room = 0, blk = 0, rflag, dflag, first = 4'hf;
	logic txen, txs, txe, txr, rxen, pop, p, ptx, prx, sel, flt;
	logic [4:0] txa, rxa;
	logic [7:0] txd;
	logic [1:0] rdp, lastp = 0;
	lp_pkg::lp_tx_word_t wr;
	lp_pkg::lp_rx_out_t ro;
	lp_pkg::lp_rx_head_t head = '0;
	logic [8:0] fq[4][$];
	logic [31:0] exq[$], gotq[$];
	int miscompares = 0, checks_done = 0;
	int nflt = 0;
	int steps[6][3] = '{'{1,0,3}, '{2,0,2}, '{2,1,1}, '{1,0,4}, '{0,0,4},
		'{0,1,1}};

	// Clocks with unrelated phase
	initial forever #5 clk = ~clk;
	initial begin
		#1.3;
		forever #3 bclk = ~bclk;
	end

	lp_link_model link (.i_clk(bclk), .o_tx_en_n(txen), .o_tx_addr(txa),
		.o_tx_data(txd), .o_tx_sop(txs), .o_tx_eop(txe), .o_tx_err(txr),
		.o_rx_en_n(rxen), .o_rx_addr(rxa));

	lp_phy_port dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_POLLED_MODE(mode),
		.I_TX_ROOM(room), .I_RX_BLOCK(blk), .I_BUS_CLK(bclk),
		.I_TX_TRANSFER_ENABLE_N(txen), .I_TX_PORT_ADDRESS(txa),
		.I_TX_DATA(txd), .I_TX_FIRST_BYTE_MARK(txs), .I_TX_LAST_BYTE_MARK(txe),
		.I_TX_ERROR_MARK(txr), .O_TX_PORT_ROOM_FLAG(rflag),
		.O_TX_POLLED_ROOM_FLAG(ptx), .O_TX_SELECTED_ROOM_FLAG(sel),
		.O_TX_SELECTED_ROOM_FLAG_OE(), .O_TX_WR(wr), .O_TX_SEQ_FAULT(flt),
		.I_RX_TRANSFER_ENABLE_N(rxen), .I_RX_PORT_ADDRESS(rxa), .O_RX_OUT(ro),
		.O_RX_OUT_OE(), .O_RX_PORT_READY_FLAG(dflag),
		.O_RX_POLLED_READY_FLAG(prx), .I_RX_HEAD(head), .O_RX_RD_PORT(rdp),
		.O_RX_RD_POP(pop));

	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Expected write word; error counts only beside the end mark
	function automatic logic [13:0] tx_exp(input logic [4:0] a,
		input logic [7:0] d, input logic s, e, r);
		return {1'b1, a[1:0], d, s, e, r && e};
	endfunction : tx_exp

	// Expected receive word {sop, err, eop, data}; err rides on data bit 0
	function automatic logic [10:0] rx_exp(input logic f,
		input logic [8:0] b);
		return {f, b[8] && b[0], b};
	endfunction : rx_exp

	task automatic cmpq(input string n, input int cnt);
		chk(n, cnt, gotq.size());
		foreach (exq[i]) if (i < gotq.size()) chk(n, exq[i], gotq[i]);
		exq = {};
		gotq = {};
	endtask : cmpq

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run

	// Show-ahead head of the buffer that the read port names
	task automatic show();
		int n;
		n = fq[rdp].size();
		head = '0;
		if (n != 0) head = {1'b1, fq[rdp][0][7:0], fq[rdp][0][8],
			fq[rdp][0][8] && fq[rdp][0][0], fq[rdp][0][8] && n == 1};
	endtask : show

	// Pop is sampled once settled, well before the edge that takes it
	always @(negedge bclk) begin
		#1 show();
		#1 p = pop;
	end

	// Taken head leaves the buffer; sop only at a packet start per port.
	// The head is refreshed off the edge only, so the design never races it
	always @(posedge bclk) begin
		if (p === 1'b1) begin
			exq.push_back(rx_exp(first[rdp], fq[rdp][0]));
			first[rdp] = fq[rdp][0][8];
			if (fq[rdp][0][8]) lastp = rdp;
			void'(fq[rdp].pop_front());
		end
		p = 0;
	end

	// Output monitor, sampled mid-cycle
	always @(negedge bclk) begin
		if (wr.valid === 1'b1) gotq.push_back(wr);
		if (ro.valid === 1'b1)
			gotq.push_back({ro.sop, ro.err, ro.eop, ro.data});
		if (flt === 1'b1) nflt++;
		if (ro.eop === 1'b1 && !mode) chk("ready_drop", 0, dflag[lastp]);
	end

	task automatic do_reset(input logic m);
		@(negedge clk);
		rst_b = 0;
		mode = m;
		foreach (fq[i]) fq[i] = {};
		first = 4'hf;
		repeat (8) @(posedge clk);
		@(negedge clk) rst_b = 1;
		repeat (10) @(negedge clk);
	endtask : do_reset

	// Long enough for the status crossing and the ready hold to finish
	task automatic wait_sync();
		repeat (12) @(negedge clk);
	endtask : wait_sync

	task automatic load(input int q, n);
		for (int i = 0; i < n; i++) fq[q].push_back({i == n - 1, 8'($urandom)});
	endtask : load

	// Packet of n bytes; error marks land anywhere and count only at the end
	task automatic pkt(input logic [4:0] a, input int n);
		logic [7:0] d;
		logic r;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			r = 1'($urandom);
			link.tx(a, d, i == 0, i == n - 1, r);
			if (a < 4) exq.push_back(tx_exp(a, d, i == 0,
				i == n - 1, r));
			if (mode && i == 1) chk("sel_release", 0, sel);
			if (mode && i == 3) chk("sel_room", room[a[1:0]], sel);
		end
	endtask : pkt

	initial begin
		void'($urandom(32'h05a0_c8ff));
		do_reset(1'b0);
		repeat (4) begin
			room = 4'($urandom);
			blk = 4'($urandom);
			wait_sync();
			chk("room_flags", room, rflag);
			chk("ready_flags", blk, dflag);
		end
		room = 4'hf;
		blk = 4'hf;
		wait_sync();
		// Switch ports with enable held; address 4 is refused
		repeat (6) pkt(5'($urandom_range(4)), 2 + $urandom_range(3));
		// Corner: byte without a start mark to a port between packets
		link.tx(5'h03, 8'h3c, 1'b0, 1'b1, 1'b0);
		exq.push_back(tx_exp(5'h03, 8'h3c, 1'b0, 1'b1, 1'b0));
		link.tx_idle(5'h00);
		repeat (3) @(negedge bclk);
		cmpq("tx_word", exq.size());
		chk("seq_fault", 1, nflt);
		// Handover, pause, resume across three ports
		load(1, 5);
		load(2, 4);
		load(0, 2);
		foreach (steps[s]) repeat (steps[s][2])
			link.rx(5'(steps[s][0]), steps[s][1] != 0);
		repeat (3) @(negedge bclk);
		cmpq("rx_byte", 9);
		do_reset(1'b1);
		room = 4'($urandom);
		blk = 4'($urandom);
		wait_sync();
		for (int a = 0; a < 4; a++) begin
			link.tx_idle(5'(a));
			link.rx(5'(a), 1'b1);
			@(negedge bclk);
			chk("poll_room", room[a], ptx);
			chk("poll_ready", blk[a], prx);
		end
		room = 4'hf;
		wait_sync();
		link.tx_idle(5'h01);
		pkt(5'h01, 5);
		link.tx_idle(5'h02);
		pkt(5'h02, 4);
		link.tx_idle(5'h01);
		pkt(5'h01, 4);
		link.tx_idle(5'h00);
		repeat (3) @(negedge bclk);
		cmpq("tx_polled", exq.size());
		chk("seq_fault", 1, nflt);
		// Same port chosen for the next packet
		load(3, 3);
		load(3, 2);
		repeat (8) link.rx(5'h03, 1'b0);
		link.rx(5'h03, 1'b1);
		repeat (3) @(negedge bclk);
		cmpq("rx_polled", 5);
		complete_run();
	end

	// Watchdog far beyond the few microseconds the tests need
	initial begin
		#100_000;
		miscompares++;
		complete_run();
	end
endmodule : testbench
